/* File: hw/uerb_pkg.sv */
// Purpose: Shared constants for the USB endpoint register block.
// Assumes: Registers sit at byte address four times their index on AHB-Lite.
// Notes:   Indices below are register indices, not byte addresses.
//
// Contract
// [RULE1] Endpoint 0 is always enabled; its enable bit changes nothing.
// [RULE2] Enable bits 1 to 3 enable endpoints 1 to 3; bits 4 to 7 read zero.
// [RULE3] Config bit 6 gives the shared 64-byte buffer to device 0, else device 1.
// [RULE4] Config bits 0 and 1 hold the device address; bits 2, 3, 7 are zero.
// [RULE5] Config bit 4 enables device 1, bit 5 enables device 2.
// [RULE6] The config register is write-only; reading it returns zero.
// [RULE7] Index write bits 0 and 1 select the endpoint for later accesses.
// [RULE8] Index write bit 2 selects receive region at zero, transmit region at one.
// [RULE9] Writing zero to index bit 3 clears receive-full of the selected endpoint.
// [RULE10] Index read gives endpoint, write-in-progress bit 2, read-in-progress bit 3.
// [RULE11] Writing status bit 2 sets the stall of the selected endpoint.
// [RULE12] Status bit 4 holds the data toggle, writable and readable.
// [RULE13] Status read bits 0 to 3: transmit ack, error, receive ack, setup.
// [RULE14] Status read bit 5 is receive-full, bit 6 transmit-empty.
// [RULE15] Status read bit 7 is direction: zero OUT, one IN.
// [RULE16] The buffer data register reads and writes bytes of the selected region.
// [RULE17] Count low read gives receive count; write loads transmit count.
// [RULE18] Any count low write arms the selected endpoint for transmission.
// [RULE19] The CPU count low register behaves exactly like count low.
// [RULE20] Main control bits 1 and 2 enable interrupts; writing zero clears pending.
// [RULE21] Each buffer data access advances a pointer; index writes restart it.
// [RULE22] Firmware fills the transmit region before writing the transmit count.

package uerb_pkg;

   // ----------------------------------------------------------------
   // Register indices
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_MAIN_IDX = 8'hA1;
   localparam logic [7:0] REG_EPEN_IDX = 8'hA5;
   localparam logic [7:0] REG_CFG_IDX  = 8'hA6;
   localparam logic [7:0] REG_SEL_IDX  = 8'hA8;
   localparam logic [7:0] REG_STAT_IDX = 8'hAA;
   localparam logic [7:0] REG_DATA_IDX = 8'hAB;
   localparam logic [7:0] REG_CNT_IDX  = 8'hAC;
   localparam logic [7:0] REG_CCNT_IDX = 8'hAE;
   localparam logic [7:0] REG_NONE_IDX = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int MAIN_RXIE_BIT = 1;
   localparam int MAIN_TXIE_BIT = 2;
   localparam int CFG_DEV1_BIT  = 4;
   localparam int CFG_DEV2_BIT  = 5;
   localparam int CFG_SHARE_BIT = 6;
   localparam int SEL_REG_BIT   = 2;
   localparam int SEL_RXCLR_BIT = 3;
   localparam int ST_STALL_BIT  = 2;
   localparam int ST_TOG_BIT    = 4;

   // ----------------------------------------------------------------
   // Sizes and reset values
   // ----------------------------------------------------------------
   localparam int         NUM_EP     = 4;
   localparam int         BUF_PTR_W  = 4;
   localparam logic [3:0] RST_EP_EN  = 4'h1;
   localparam logic       RST_SHARE0 = 1'b0;

endpackage

/* File: hw/uerb_mem_if.sv */
// Purpose: Carrier between the register logic and the endpoint buffer memory.
// Assumes: Both ports run on the block clock.
// Notes:   Port a belongs to the CPU side, port b to the serial engine.

interface uerb_mem_if #(parameter int AW = 7);
   logic          a_we;
   logic [AW-1:0] a_addr;
   logic [7:0]    a_wdata;
   logic [7:0]    a_rdata;
   logic          b_we;
   logic [AW-1:0] b_addr;
   logic [7:0]    b_wdata;
   logic [7:0]    b_rdata;

   modport ctl (output a_we, a_addr, a_wdata, b_we, b_addr, b_wdata, input a_rdata, b_rdata);
   modport mem (input a_we, a_addr, a_wdata, b_we, b_addr, b_wdata, output a_rdata, b_rdata);
endinterface

/* File: hw/uerb_buf_mem.sv */
// Purpose: Dual-port endpoint buffer with registered read data.
// Assumes: Both ports on one clock.
// Notes:   On a same-address write clash the serial engine port wins.

module uerb_buf_mem #(
   parameter int AW = 7
) (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Memory ports
   uerb_mem_if.mem   mp
);

   typedef struct packed {
      logic [(1<<AW)-1:0][7:0] ram;
      logic [7:0]              a_rd;
      logic [7:0]              b_rd;
   } uerb_mem_s;

   uerb_mem_s m_q;
   uerb_mem_s m_d;

   always_comb
   begin
      m_d      = m_q;
      m_d.a_rd = m_q.ram[mp.a_addr];
      m_d.b_rd = m_q.ram[mp.b_addr];
      if (mp.a_we)
      begin
         m_d.ram[mp.a_addr] = mp.a_wdata;
      end
      if (mp.b_we)
      begin
         m_d.ram[mp.b_addr] = mp.b_wdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         m_q <= '0;
      end
      else
      begin
         m_q <= m_d;
      end
   end

   assign mp.a_rdata = m_q.a_rd;
   assign mp.b_rdata = m_q.b_rd;

endmodule

/* File: hw/uerb_top.sv */
// Purpose: Endpoint register block between CPU firmware and the serial engine.
// Assumes: Serial engine signals are synchronous to hclk.
// Notes:   Register reads take one wait state, buffer data reads take two.

module uerb_top
   import uerb_pkg::*;
#(
   parameter int PTR_W = BUF_PTR_W
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Serial engine events
   input  wire logic [1:0]  sie_ep,
   input  wire logic        sie_rx_ok,
   input  wire logic        sie_setup,
   input  wire logic [7:0]  sie_rx_cnt,
   input  wire logic        sie_tx_ok,
   input  wire logic        sie_err,
   // Serial engine buffer port
   input  wire logic                 sie_mem_we,
   input  wire logic [PTR_W+2:0]     sie_mem_addr,
   input  wire logic [7:0]           sie_mem_wdata,
   output logic [7:0]                sie_mem_rdata,
   // Endpoint controls to the serial engine
   output logic [NUM_EP-1:0] ep_enable,
   output logic [NUM_EP-1:0] ep_stall,
   output logic [NUM_EP-1:0] ep_toggle,
   output logic [NUM_EP-1:0] transmit_armed_flag,
   output logic [7:0]        sie_tx_cnt,
   output logic [1:0]        dev_addr,
   output logic              dev1_en,
   output logic              dev2_en,
   output logic              share_dev0,
   output logic              usb_irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                       dp_act;
      logic                       dp_wr;
      logic [7:0]                 dp_idx;
      logic                       rd_ph;
      logic                       hready;
      logic [31:0]                hrdata;
      logic                       hresp;
      logic [NUM_EP-1:0]          ep_en;
      logic [1:0]                 dev_addr;
      logic                       dev1_en;
      logic                       dev2_en;
      logic                       share0;
      logic [1:0]                 ie;
      logic                       irq_rx;
      logic                       irq_tx;
      logic                       irq;
      logic [1:0]                 sel;
      logic                       region;
      logic [PTR_W-1:0]           ptr;
      logic                       wr_busy;
      logic                       rd_busy;
      logic [NUM_EP-1:0]          stall;
      logic [NUM_EP-1:0]          tog;
      logic [NUM_EP-1:0]          ack_tx;
      logic [NUM_EP-1:0]          err;
      logic [NUM_EP-1:0]          ack_rx;
      logic [NUM_EP-1:0]          setup;
      logic [NUM_EP-1:0]          rx_full;
      logic [NUM_EP-1:0]          tx_armed;
      logic [NUM_EP-1:0]          dir;
      logic [NUM_EP-1:0][7:0]     rx_cnt;
      logic [NUM_EP-1:0][7:0]     tx_cnt;
      logic [7:0]                 sie_tx_cnt;
   } uerb_st_s;

   uerb_st_s s_q;
   uerb_st_s s_d;

   logic       accept;
   logic [7:0] acc_idx;
   logic [7:0] rd_val;
   logic [7:0] wd;

   uerb_mem_if #(.AW(PTR_W + 3)) mif ();

   uerb_buf_mem #(.AW(PTR_W + 3)) u_mem (
      .hclk    (hclk),
      .hresetn (hresetn),
      .mp      (mif.mem)
   );

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   // Only aligned word addresses inside the 1 KB window map; anything else
   // decodes to an index that reads zero and ignores writes.
   always_comb
   begin
      accept  = hsel && htrans[1] && hready;
      acc_idx = REG_NONE_IDX;
      if ((haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0))
      begin
         acc_idx = haddr[9:2];
      end
   end

   // ----------------------------------------------------------------
   // Read data selection
   // ----------------------------------------------------------------
   always_comb
   begin
      unique case (s_q.dp_idx)
         REG_MAIN_IDX: rd_val = {5'h0, s_q.ie, 1'b0};
         REG_EPEN_IDX: rd_val = {4'h0, s_q.ep_en}; // RULE2
         REG_SEL_IDX:  rd_val = {4'h0, s_q.rd_busy, s_q.wr_busy, s_q.sel}; // RULE10
         REG_STAT_IDX: rd_val = {s_q.dir[s_q.sel], ~s_q.tx_armed[s_q.sel], // RULE15 RULE14
                                 s_q.rx_full[s_q.sel], s_q.tog[s_q.sel], // RULE12
                                 s_q.setup[s_q.sel], s_q.ack_rx[s_q.sel], // RULE13
                                 s_q.err[s_q.sel], s_q.ack_tx[s_q.sel]};
         REG_CNT_IDX:  rd_val = s_q.rx_cnt[s_q.sel]; // RULE17
         REG_CCNT_IDX: rd_val = s_q.rx_cnt[s_q.sel]; // RULE19
         default:      rd_val = 8'h00; // RULE6
      endcase
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d          = s_q;
      wd           = hwdata[7:0];
      s_d.ep_en[0] = 1'b1; // RULE1
      s_d.wr_busy  = 1'b0;
      s_d.hresp    = 1'b0;
      mif.a_we     = 1'b0;
      mif.a_addr   = {s_q.sel, s_q.region, s_q.ptr}; // RULE16
      mif.a_wdata  = wd;
      mif.b_we     = sie_mem_we;
      mif.b_addr   = sie_mem_addr;
      mif.b_wdata  = sie_mem_wdata;

      // Write data phase; writes never wait.
      if (s_q.dp_act && s_q.dp_wr)
      begin
         unique case (s_q.dp_idx)
            REG_MAIN_IDX:
            begin
               s_d.ie = {wd[MAIN_TXIE_BIT], wd[MAIN_RXIE_BIT]}; // RULE20
               if (!wd[MAIN_RXIE_BIT])
               begin
                  s_d.irq_rx = 1'b0; // RULE20
               end
               if (!wd[MAIN_TXIE_BIT])
               begin
                  s_d.irq_tx = 1'b0;
               end
            end
            REG_EPEN_IDX:
            begin
               s_d.ep_en[NUM_EP-1:1] = wd[NUM_EP-1:1]; // RULE2
            end
            REG_CFG_IDX:
            begin
               s_d.dev_addr = wd[1:0]; // RULE4
               s_d.dev1_en  = wd[CFG_DEV1_BIT]; // RULE5
               s_d.dev2_en  = wd[CFG_DEV2_BIT];
               s_d.share0   = wd[CFG_SHARE_BIT]; // RULE3
            end
            REG_SEL_IDX:
            begin
               s_d.sel    = wd[1:0]; // RULE7
               s_d.region = wd[SEL_REG_BIT]; // RULE8
               s_d.ptr    = '0; // RULE21
               if (!wd[SEL_RXCLR_BIT])
               begin
                  s_d.rx_full[wd[1:0]] = 1'b0; // RULE9
               end
            end
            REG_STAT_IDX:
            begin
               s_d.stall[s_q.sel] = wd[ST_STALL_BIT]; // RULE11
               s_d.tog[s_q.sel]   = wd[ST_TOG_BIT]; // RULE12
            end
            REG_DATA_IDX:
            begin
               mif.a_we    = 1'b1; // RULE16
               s_d.ptr     = s_q.ptr + 1'b1; // RULE21
               s_d.wr_busy = 1'b1; // RULE10
            end
            REG_CNT_IDX, REG_CCNT_IDX:
            begin
               // The count write arms the endpoint, so the region must be filled first.
               s_d.tx_cnt[s_q.sel]   = wd; // RULE17 RULE19 RULE22
               s_d.tx_armed[s_q.sel] = 1'b1; // RULE18
            end
            default:
            begin
            end
         endcase
      end

      // Read data phase, stretched by wait states.
      if (s_q.dp_act && !s_q.dp_wr && !s_q.hready)
      begin
         if ((s_q.dp_idx == REG_DATA_IDX) && !s_q.rd_ph)
         begin
            s_d.rd_ph   = 1'b1;
            s_d.ptr     = s_q.ptr + 1'b1; // RULE21
            s_d.rd_busy = 1'b1; // RULE10
         end
         else
         begin
            s_d.rd_ph   = 1'b0;
            s_d.rd_busy = 1'b0;
            s_d.hready  = 1'b1;
            s_d.hrdata  = (s_q.dp_idx == REG_DATA_IDX) ? {24'h0, mif.a_rdata} : {24'h0, rd_val}; // RULE16
         end
      end

      // Address phase.
      if (s_q.hready)
      begin
         s_d.dp_act = accept;
         s_d.dp_wr  = hwrite;
         s_d.dp_idx = acc_idx;
         if (accept && !hwrite)
         begin
            s_d.hready = 1'b0;
         end
      end

      // Engine events come last so that an engine event beats a register write in the same cycle.
      if (s_q.ep_en[sie_ep])
      begin
         if (sie_rx_ok)
         begin
            s_d.rx_full[sie_ep] = 1'b1;
            s_d.ack_rx[sie_ep]  = 1'b1;
            s_d.err[sie_ep]     = 1'b0;
            s_d.setup[sie_ep]   = sie_setup;
            s_d.dir[sie_ep]     = 1'b0;
            s_d.rx_cnt[sie_ep]  = sie_rx_cnt;
            s_d.tog[sie_ep]     = ~s_q.tog[sie_ep];
            if (s_q.ie[0])
            begin
               s_d.irq_rx = 1'b1;
            end
         end
         if (sie_tx_ok)
         begin
            s_d.ack_tx[sie_ep]   = 1'b1;
            s_d.err[sie_ep]      = 1'b0;
            s_d.tx_armed[sie_ep] = 1'b0;
            s_d.dir[sie_ep]      = 1'b1;
            s_d.tog[sie_ep]      = ~s_q.tog[sie_ep];
            if (s_q.ie[1])
            begin
               s_d.irq_tx = 1'b1;
            end
         end
         if (sie_err)
         begin
            s_d.err[sie_ep]    = 1'b1;
            s_d.ack_rx[sie_ep] = 1'b0;
            s_d.ack_tx[sie_ep] = 1'b0;
         end
      end

      s_d.irq        = s_d.irq_rx || s_d.irq_tx;
      s_d.sie_tx_cnt = s_q.tx_cnt[sie_ep];
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_q        <= '0;
         s_q.ep_en  <= RST_EP_EN;
         s_q.share0 <= RST_SHARE0;
         s_q.hready <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign hreadyout           = s_q.hready;
   assign hrdata              = s_q.hrdata;
   assign hresp               = s_q.hresp;
   assign sie_mem_rdata       = mif.b_rdata;
   assign ep_enable           = s_q.ep_en;
   assign ep_stall            = s_q.stall;
   assign ep_toggle           = s_q.tog;
   assign transmit_armed_flag = s_q.tx_armed;
   assign sie_tx_cnt          = s_q.sie_tx_cnt;
   assign dev_addr            = s_q.dev_addr;
   assign dev1_en             = s_q.dev1_en;
   assign dev2_en             = s_q.dev2_en;
   assign share_dev0          = s_q.share0;
   assign usb_irq             = s_q.irq;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_ep0_always_on: // RULE1
      assert property (s_q.ep_en[0])
      else $error("endpoint 0 enable dropped");

   a_epen_high_zero: // RULE2
      assert property ((s_q.dp_act && !s_q.dp_wr && s_q.dp_idx == REG_EPEN_IDX && !s_q.hready)
                       |=> s_q.hready && (s_q.hrdata[31:4] == 28'h0))
      else $error("endpoint enable upper bits not zero");

   a_cfg_reads_zero: // RULE6
      assert property ((accept && !hwrite && acc_idx == REG_CFG_IDX && s_q.hready)
                       |=> !s_q.hready ##1 (s_q.hready && s_q.hrdata == 32'h0))
      else $error("config register read returned data");

   a_sel_restarts: // RULE21
      assert property ((s_q.dp_act && s_q.dp_wr && s_q.dp_idx == REG_SEL_IDX)
                       |=> (s_q.ptr == '0) && (s_q.sel == $past(hwdata[1:0])))
      else $error("select write did not restart pointer");

   a_rxfull_clear: // RULE9
      assert property ((s_q.dp_act && s_q.dp_wr && s_q.dp_idx == REG_SEL_IDX
                        && !hwdata[SEL_RXCLR_BIT] && !sie_rx_ok)
                       |=> !s_q.rx_full[$past(hwdata[1:0])])
      else $error("receive full not cleared");

   a_stall_set: // RULE11
      assert property ((s_q.dp_act && s_q.dp_wr && s_q.dp_idx == REG_STAT_IDX && hwdata[ST_STALL_BIT])
                       |=> s_q.stall[$past(s_q.sel)])
      else $error("stall not set");

   a_count_arms: // RULE18
      assert property ((s_q.dp_act && s_q.dp_wr && s_q.dp_idx == REG_CNT_IDX && !sie_tx_ok)
                       |=> s_q.tx_armed[$past(s_q.sel)] && (s_q.tx_cnt[$past(s_q.sel)] == $past(hwdata[7:0])))
      else $error("count write did not arm endpoint");

   a_buf_rd_wait: // RULE16
      assert property ((accept && !hwrite && acc_idx == REG_DATA_IDX && s_q.hready)
                       |=> !s_q.hready ##1 (!s_q.hready && s_q.rd_busy) ##1 s_q.hready)
      else $error("buffer read wait states wrong");

   a_irq_cleared: // RULE20
      assert property ((s_q.dp_act && s_q.dp_wr && s_q.dp_idx == REG_MAIN_IDX
                        && !hwdata[MAIN_RXIE_BIT] && !hwdata[MAIN_TXIE_BIT] && !sie_rx_ok && !sie_tx_ok)
                       |=> !s_q.irq_rx ##1 !usb_irq)
      else $error("pending interrupt not cleared");

endmodule

/* File: dv/uerb_sie_model.sv */
// Purpose: Behavioural serial engine that raises endpoint events and moves buffer bytes.
// Assumes: Every engine signal changes just after a rising edge of hclk.
// Notes:   Idle count and data lines show the inverse of their last value.

module uerb_sie_model (
   // Clock
   input  wire logic       hclk,
   // Engine events and buffer port
   output logic [1:0]      sie_ep,
   output logic            sie_rx_ok,
   output logic            sie_setup,
   output logic [7:0]      sie_rx_cnt,
   output logic            sie_tx_ok,
   output logic            sie_err,
   output logic            sie_mem_we,
   output logic [6:0]      sie_mem_addr,
   output logic [7:0]      sie_mem_wdata,
   input  wire logic [7:0] sie_mem_rdata
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      {sie_ep, sie_rx_ok, sie_setup, sie_rx_cnt, sie_tx_ok, sie_err} = '0;
      {sie_mem_we, sie_mem_addr, sie_mem_wdata} = '0;
   end

   // Kind bit 0 is receive, bit 1 transmit acknowledged, bit 2 error; the endpoint stays as a level.
   task automatic ev(input logic [1:0] ep, input logic [2:0] k, input logic su, input logic [7:0] n);
      @(posedge hclk);
      sie_ep     <= ep;
      {sie_err, sie_tx_ok, sie_rx_ok} <= k;
      sie_setup  <= su;
      sie_rx_cnt <= n;
      @(posedge hclk);
      {sie_err, sie_tx_ok, sie_rx_ok} <= 3'b000;
      sie_setup  <= ~su;
      sie_rx_cnt <= ~n;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge hclk);
      sie_mem_we    <= 1'b1;
      sie_mem_addr  <= a;
      sie_mem_wdata <= d;
      @(posedge hclk);
      sie_mem_we    <= 1'b0;
      sie_mem_wdata <= ~d;
   endtask

   // Read data is registered, so it is taken one edge after the address was seen.
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge hclk);
      sie_mem_addr <= a;
      repeat (2) @(posedge hclk);
      d = sie_mem_rdata;
   endtask
endmodule

/* File: dv/usb_endpoint_register_block_tb.sv */
// Purpose: Self-checking bench for the USB endpoint register block.
// Assumes: One AHB-Lite master and the engine model share hclk.
// Notes:   Expected values are worked out by hand from the register map.

module usb_endpoint_register_block_tb
   import uerb_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        hclk     = 1'b0;
   logic        hresetn  = 1'b0;
   logic [31:0] haddr    = '0;
   logic [1:0]  htrans   = 2'b00;
   logic        hwrite   = 1'b0;
   logic [31:0] hwdata   = '0;
   logic        hreadyout, hresp;
   logic [31:0] hrdata;
   logic [1:0]  sie_ep, dev_addr;
   logic        sie_rx_ok, sie_setup, sie_tx_ok, sie_err, sie_mem_we;
   logic [7:0]  sie_rx_cnt, sie_mem_wdata, sie_mem_rdata, sie_tx_cnt;
   logic [6:0]  sie_mem_addr;
   logic [3:0]  ep_enable, ep_stall, ep_toggle, transmit_armed_flag;
   logic        dev1_en, dev2_en, share_dev0, usb_irq;
   int          failures = 0;
   int          n_checks = 0;
   int          cycles   = 0;

   always #2 hclk = ~hclk;

   uerb_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .sie_ep(sie_ep), .sie_rx_ok(sie_rx_ok), .sie_setup(sie_setup),
      .sie_rx_cnt(sie_rx_cnt), .sie_tx_ok(sie_tx_ok), .sie_err(sie_err), .sie_mem_we(sie_mem_we),
      .sie_mem_addr(sie_mem_addr), .sie_mem_wdata(sie_mem_wdata), .sie_mem_rdata(sie_mem_rdata),
      .ep_enable(ep_enable), .ep_stall(ep_stall), .ep_toggle(ep_toggle),
      .transmit_armed_flag(transmit_armed_flag), .sie_tx_cnt(sie_tx_cnt), .dev_addr(dev_addr),
      .dev1_en(dev1_en), .dev2_en(dev2_en), .share_dev0(share_dev0), .usb_irq(usb_irq));

   uerb_sie_model sie (.hclk(hclk), .sie_ep(sie_ep), .sie_rx_ok(sie_rx_ok), .sie_setup(sie_setup),
      .sie_rx_cnt(sie_rx_cnt), .sie_tx_ok(sie_tx_ok), .sie_err(sie_err), .sie_mem_we(sie_mem_we),
      .sie_mem_addr(sie_mem_addr), .sie_mem_wdata(sie_mem_wdata), .sie_mem_rdata(sie_mem_rdata));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   // The master never assumes a wait count; only the watchdog ends a stuck wait.
   task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h000000, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] x;
      bus(1'b1, {22'h000000, idx, 2'b00}, d, x);
   endtask

   task automatic rc(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e, input string nm);
      logic [31:0] d;
      bus(1'b0, {22'h000000, idx, 2'b00}, 8'h00, d);
      chk(nm, d & {24'hFFFFFF, m}, {24'h000000, e});
   endtask

   task automatic settle;
      repeat (2) @(negedge hclk);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_enable;
      chk("ep_enable", ep_enable, 32'h1);
      wr(REG_EPEN_IDX, 8'hFF);
      settle;
      chk("ep_enable", ep_enable, 32'hF);
      rc(REG_EPEN_IDX, 8'hFF, 8'h0F, "enable");
      wr(REG_EPEN_IDX, 8'h00);
      settle;
      chk("ep_enable", ep_enable, 32'h1);
      sie.ev(2'd0, 3'b001, 1'b0, 8'h03);
      wr(REG_SEL_IDX, 8'h08);
      rc(REG_CNT_IDX, 8'hFF, 8'h03, "ep0 count");
      wr(REG_EPEN_IDX, 8'h06);
      settle;
      chk("ep_enable", ep_enable, 32'h7);
   endtask

   task automatic t_config;
      wr(REG_CFG_IDX, 8'hFF);
      settle;
      chk("config", {dev_addr, dev1_en, dev2_en, share_dev0}, 32'h1F);
      rc(REG_CFG_IDX, 8'hFF, 8'h00, "config read");
      wr(REG_CFG_IDX, 8'h11);
      settle;
      chk("config", {dev_addr, dev1_en, dev2_en, share_dev0}, 32'h0C);
   endtask

   task automatic t_status;
      wr(REG_SEL_IDX, 8'h0A);
      rc(REG_SEL_IDX, 8'hFF, 8'h02, "index");
      wr(REG_STAT_IDX, 8'h14);
      settle;
      // Endpoint 0 toggle is still one from the receive event in the enable scenario.
      chk("stall toggle", {ep_stall, ep_toggle}, 32'h45);
      rc(REG_STAT_IDX, 8'hFF, 8'h50, "status");
   endtask

   task automatic t_receive;
      wr(REG_MAIN_IDX, 8'h02);
      sie.ev(2'd2, 3'b001, 1'b1, 8'h05);
      settle;
      chk("irq", usb_irq, 32'h1);
      rc(REG_MAIN_IDX, 8'hFF, 8'h02, "main");
      rc(REG_STAT_IDX, 8'hFF, 8'h6C, "status rx");
      rc(REG_CNT_IDX, 8'hFF, 8'h05, "count");
      rc(REG_CCNT_IDX, 8'hFF, 8'h05, "cpu count");
      wr(REG_MAIN_IDX, 8'h00);
      settle;
      chk("irq", usb_irq, 32'h0);
      wr(REG_SEL_IDX, 8'h02);
      rc(REG_STAT_IDX, 8'hFF, 8'h4C, "status clr");
   endtask

   task automatic t_transmit;
      logic [7:0] b;
      wr(REG_SEL_IDX, 8'h0E);
      // Bytes go in before the count, since the count write arms the endpoint.
      for (int i = 0; i < 3; i++) wr(REG_DATA_IDX, 8'hA0 + 8'(i));
      wr(REG_CNT_IDX, 8'h03);
      settle;
      chk("armed", transmit_armed_flag, 32'h4);
      chk("tx count", sie_tx_cnt, 32'h3);
      rc(REG_STAT_IDX, 8'h40, 8'h00, "tx empty");
      sie.rd(7'h51, b);
      chk("tx byte", b, 32'hA1);
      sie.ev(2'd2, 3'b010, 1'b0, 8'h00);
      settle;
      chk("armed", transmit_armed_flag, 32'h0);
      rc(REG_STAT_IDX, 8'hD1, 8'hD1, "status tx");
      wr(REG_CCNT_IDX, 8'h07);
      settle;
      chk("armed", transmit_armed_flag, 32'h4);
      chk("tx count", sie_tx_cnt, 32'h7);
      rc(REG_CCNT_IDX, 8'hFF, 8'h05, "cpu count");
   endtask

   task automatic t_error;
      sie.ev(2'd2, 3'b100, 1'b0, 8'h00);
      rc(REG_STAT_IDX, 8'h07, 8'h02, "status err");
   endtask

   task automatic t_rx_buffer;
      sie.wr(7'h20, 8'h3C);
      sie.wr(7'h21, 8'hC3);
      wr(REG_SEL_IDX, 8'h09);
      rc(REG_DATA_IDX, 8'hFF, 8'h3C, "rx byte0");
      rc(REG_DATA_IDX, 8'hFF, 8'hC3, "rx byte1");
      wr(REG_SEL_IDX, 8'h09);
      rc(REG_DATA_IDX, 8'hFF, 8'h3C, "rx restart");
   endtask

   task automatic t_refused;
      logic [31:0] d;
      sie.ev(2'd3, 3'b001, 1'b0, 8'h09);
      wr(REG_SEL_IDX, 8'h0B);
      rc(REG_STAT_IDX, 8'h24, 8'h00, "ep3 status");
      rc(REG_CNT_IDX, 8'hFF, 8'h00, "ep3 count");
      bus(1'b1, 32'h00000400, 8'h5A, d);
      bus(1'b0, 32'h00000400, 8'h00, d);
      chk("unmapped", d, 32'h0);
      chk("hresp", hresp, 32'h0);
   endtask

   // ----------------------------------------------------------------
   // Run control
   // ----------------------------------------------------------------
   task automatic stop_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         failures++;
         stop_test();
      end
   end

   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      settle;
      t_enable();
      t_config();
      t_status();
      t_receive();
      t_transmit();
      t_error();
      t_rx_buffer();
      t_refused();
      stop_test();
   end
endmodule
